// File: hw/tlasa_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the limit alert block.
// Assumes: Included by its bare name by every file that needs a constant.
// Notes: Definitions only.
`ifndef TLASA_DEFINES_SVH
`define TLASA_DEFINES_SVH

`define TLASA_PTR_TEMP 2'h0
`define TLASA_PTR_CONF 2'h1
`define TLASA_PTR_LOW 2'h2
`define TLASA_PTR_HIGH 2'h3

`define TLASA_CONF_ONE_SHOT 7
`define TLASA_CONF_RATE_HI 6
`define TLASA_CONF_RATE_LO 5
`define TLASA_CONF_FQ_HI 4
`define TLASA_CONF_FQ_LO 3
`define TLASA_CONF_POLARITY 2
`define TLASA_CONF_MODE_SEL 1
`define TLASA_CONF_SHUTDOWN 0

`define TLASA_CONF_RESET 7'h28
`define TLASA_HIGH_RESET 12'h500
`define TLASA_LOW_RESET 12'h4B0
`define TLASA_TEMP_RESET 12'h000

`define TLASA_GC_ADDR 7'h00
`define TLASA_ARA_ADDR 7'h0C
`define TLASA_GC_RESET_CMD 8'h06
`define TLASA_BITS_PER_BYTE 4'h8

`define TLASA_FAULTS_1 3'h1
`define TLASA_FAULTS_2 3'h2
`define TLASA_FAULTS_4 3'h4
`define TLASA_FAULTS_6 3'h6

`endif

// File: hw/tlasa_pkg.sv
// Purpose: Types shared by the limit alert block.
// Assumes: Nothing is imported; users write tlasa_pkg::name.
// Notes: Protocol states are one-hot.
package tlasa_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ACK_ADDR = 7'h04,
		ST_WRITE = 7'h08,
		ST_ACK_WRITE = 7'h10,
		ST_READ = 7'h20,
		ST_ACK_READ = 7'h40
	} tlasa_state_t;
endpackage

// File: hw/tlasa_sync.sv
// Purpose: Two flip-flop synchroniser for one pin.
// Assumes: The pin is asynchronous to clock_in.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module tlasa_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic d_in,
	output logic q_out
);
	logic stage1;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			stage1 <= RESET_VAL;
			q_out <= RESET_VAL;
		end else begin
			stage1 <= d_in;
			q_out <= stage1;
		end
	end
endmodule

// File: hw/tlasa_sensor.sv
// Purpose: Limit alert logic, limit and configuration registers, two-wire target port.
// Assumes: The converter starts on conv_start_out and returns conv_done_in with a result.
// Notes: SCL and SDA are sampled by clock_in; SDA is open drain through sda_oe_out.
// How it works
// - In shutdown, one-shot bit starts one conversion.
// - After a one-shot result, return to shutdown.
// - Configuration reads show zero in one-shot bit.
// - Comparator mode: alert after N faults at or above upper.
// - Comparator mode: release after N results below lower.
// - Interrupt mode: alert after N faults at or above upper.
// - Interrupt alert held until read or ARA.
// - Writing shutdown also clears interrupt alert.
// - After upper event clears, next alert below lower.
// - Then re-arm upper; alternate between thresholds forever.
// - General call reset resets device, clears alert.
// - Mode change in either direction clears alert state.
// - Limit bytes move most significant byte first.
// - Reset limits: upper 80 degrees, lower 75.
// - Limits are 12 bits, low nibble reads zero.
// - Nine clocks per byte: eight data, one ack.
// - Device acknowledges low; host releases SDA then.
// - Both release SDA in the final not-ack slot.
// - Device drives read data; host only acks.
// - Fault queue field selects 1, 2, 4, 6.
// - Polarity bit zero gives an active low alert.
// - Shutdown waits for the running conversion; else continuous.
`timescale 1ns/1ps
`include "tlasa_defines.svh"
module tlasa_sensor #(
	// Target address; the value is arbitrary.
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic conv_done_in,
	input wire logic [11:0] conv_temp_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic alert_out,
	output logic conv_start_out,
	output logic [1:0] conv_rate_out
);
	logic scl_s, sda_s, scl_q, sda_q;
	tlasa_pkg::tlasa_state_t state;
	logic [7:0] shift, msb_hold;
	logic [3:0] bit_cnt;
	logic [1:0] byte_idx, ptr;
	logic is_read, is_ara, is_gc;
	logic [6:0] conf;
	logic [11:0] upper, lower, temp;
	logic conv_busy, single_pend;
	logic alert, arm_high;
	logic [2:0] fault_cnt;

	tlasa_sync #(.RESET_VAL(1'b1)) u_scl_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.d_in(scl_in),
		.q_out(scl_s)
	);
	tlasa_sync #(.RESET_VAL(1'b1)) u_sda_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.d_in(sda_in),
		.q_out(sda_s)
	);

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_det = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
	wire byte_full = bit_cnt == `TLASA_BITS_PER_BYTE;
	wire [6:0] rx_addr = shift[7:1];
	wire match_dev = rx_addr == DEV_ADDR;
	wire match_gc = (rx_addr == `TLASA_GC_ADDR) && !shift[0];
	// The alert response address is only answered while an alert is pending.
	wire match_ara = (rx_addr == `TLASA_ARA_ADDR) && shift[0] && alert;
	wire addr_hit = match_dev | match_gc | match_ara;
	// Losing arbitration: we released SDA for a one but the line reads low.
	wire arb_lost = is_ara && shift[7] && !sda_s;

	wire [11:0] sel_val = (ptr == `TLASA_PTR_HIGH) ? upper :
		(ptr == `TLASA_PTR_LOW) ? lower : temp;
	wire [7:0] word_byte = (byte_idx == 2'h0) ? sel_val[11:4] : {sel_val[3:0], 4'h0};
	wire [7:0] reg_byte = (ptr == `TLASA_PTR_CONF) ? {1'b0, conf} : word_byte;
	wire [7:0] rd_byte = is_ara ? {DEV_ADDR, 1'b0} : reg_byte;

	wire wr_byte = (state == tlasa_pkg::ST_WRITE) && scl_fall && byte_full;
	wire wr_ptr = wr_byte && !is_gc && (byte_idx == 2'h0);
	wire wr_conf = wr_byte && !is_gc && (byte_idx == 2'h1) && (ptr == `TLASA_PTR_CONF);
	wire wr_msb = wr_byte && !is_gc && (byte_idx == 2'h1) && ptr[1];
	wire wr_lsb = wr_byte && !is_gc && (byte_idx == 2'h2) && ptr[1];
	wire gc_reset = wr_byte && is_gc && (shift == `TLASA_GC_RESET_CMD);
	wire ack_rise = (state == tlasa_pkg::ST_ACK_READ) && scl_rise;
	wire rd_done = ack_rise && !is_ara;
	wire ara_done = ack_rise && is_ara;

	assign sda_out = 1'b0;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state <= tlasa_pkg::ST_IDLE;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			byte_idx <= 2'h0;
			is_read <= 1'b0;
			is_ara <= 1'b0;
			is_gc <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (stop_det) begin
			state <= tlasa_pkg::ST_IDLE;
			sda_oe_out <= 1'b0;
		end else if (start_det) begin
			state <= tlasa_pkg::ST_ADDR;
			bit_cnt <= 4'h0;
			sda_oe_out <= 1'b0;
		end else begin
			unique case (state)
				tlasa_pkg::ST_IDLE: begin
				end
				tlasa_pkg::ST_ADDR: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_full) begin
						if (addr_hit) begin
							state <= tlasa_pkg::ST_ACK_ADDR;
							sda_oe_out <= 1'b1;
							is_read <= shift[0];
							is_ara <= match_ara;
							is_gc <= match_gc;
							byte_idx <= 2'h0;
						end else begin
							state <= tlasa_pkg::ST_IDLE;
						end
					end
				end
				tlasa_pkg::ST_ACK_ADDR: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (is_read) begin
							state <= tlasa_pkg::ST_READ;
							shift <= rd_byte;
							sda_oe_out <= ~rd_byte[7];
						end else begin
							state <= tlasa_pkg::ST_WRITE;
							sda_oe_out <= 1'b0;
						end
					end
				end
				tlasa_pkg::ST_WRITE: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_full) begin
						state <= tlasa_pkg::ST_ACK_WRITE;
						sda_oe_out <= 1'b1;
					end
				end
				tlasa_pkg::ST_ACK_WRITE: begin
					if (scl_fall) begin
						state <= tlasa_pkg::ST_WRITE;
						sda_oe_out <= 1'b0;
						bit_cnt <= 4'h0;
						byte_idx <= (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;
					end
				end
				tlasa_pkg::ST_READ: begin
					if (scl_rise) begin
						if (arb_lost) begin
							state <= tlasa_pkg::ST_IDLE;
							sda_oe_out <= 1'b0;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
						end
					end else if (scl_fall) begin
						if (byte_full) begin
							state <= tlasa_pkg::ST_ACK_READ;
							sda_oe_out <= 1'b0;
						end else begin
							shift <= {shift[6:0], 1'b0};
							sda_oe_out <= ~shift[6];
						end
					end
				end
				tlasa_pkg::ST_ACK_READ: begin
					if (scl_rise) begin
						if (sda_s) begin
							state <= tlasa_pkg::ST_IDLE;
						end else begin
							byte_idx <= 2'h1;
						end
					end else if (scl_fall) begin
						state <= tlasa_pkg::ST_READ;
						bit_cnt <= 4'h0;
						shift <= rd_byte;
						sda_oe_out <= ~rd_byte[7];
					end
				end
			endcase
		end
	end

	wire conv_fin = conv_done_in && conv_busy;
	// A one-shot request is only meaningful when the same write keeps shutdown set.
	wire single_req = wr_conf && shift[`TLASA_CONF_ONE_SHOT] && shift[`TLASA_CONF_SHUTDOWN];
	wire want_conv = !conf[`TLASA_CONF_SHUTDOWN] || single_pend;
	wire start_now = !conv_busy && want_conv;
	assign conv_rate_out = conf[`TLASA_CONF_RATE_HI:`TLASA_CONF_RATE_LO];

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ptr <= `TLASA_PTR_TEMP;
			conf <= `TLASA_CONF_RESET;
			upper <= `TLASA_HIGH_RESET;
			lower <= `TLASA_LOW_RESET;
			temp <= `TLASA_TEMP_RESET;
			msb_hold <= 8'h00;
		end else if (gc_reset) begin
			ptr <= `TLASA_PTR_TEMP;
			conf <= `TLASA_CONF_RESET;
			upper <= `TLASA_HIGH_RESET;
			lower <= `TLASA_LOW_RESET;
			temp <= `TLASA_TEMP_RESET;
			msb_hold <= 8'h00;
		end else begin
			if (wr_ptr) ptr <= shift[1:0];
			if (wr_conf) conf <= shift[6:0];
			if (wr_msb) msb_hold <= shift;
			if (wr_lsb && ptr == `TLASA_PTR_HIGH) upper <= {msb_hold, shift[7:4]};
			if (wr_lsb && ptr == `TLASA_PTR_LOW) lower <= {msb_hold, shift[7:4]};
			if (conv_fin) temp <= conv_temp_in;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			conv_busy <= 1'b0;
			single_pend <= 1'b0;
			conv_start_out <= 1'b0;
		end else if (gc_reset) begin
			conv_busy <= 1'b0;
			single_pend <= 1'b0;
			conv_start_out <= 1'b0;
		end else begin
			conv_start_out <= start_now;
			single_pend <= single_req | (single_pend & ~start_now);
			conv_busy <= start_now | (conv_busy & ~conv_fin);
		end
	end

	wire int_mode = conf[`TLASA_CONF_MODE_SEL];
	wire [1:0] fq = conf[`TLASA_CONF_FQ_HI:`TLASA_CONF_FQ_LO];
	wire [2:0] fault_need = (fq == 2'h0) ? `TLASA_FAULTS_1 : (fq == 2'h1) ? `TLASA_FAULTS_2 :
		(fq == 2'h2) ? `TLASA_FAULTS_4 : `TLASA_FAULTS_6;
	wire over = $signed(conv_temp_in) >= $signed(upper);
	wire under = $signed(conv_temp_in) < $signed(lower);
	wire cond = arm_high ? over : under;
	// In interrupt mode a pending alert freezes qualification until it is cleared.
	wire counting = conv_fin && (!int_mode || !alert);
	// A shorter queue written mid-count qualifies at once instead of wrapping.
	wire qualify = counting && cond && (fault_cnt + 3'h1 >= fault_need);
	wire mode_chg = wr_conf && (shift[`TLASA_CONF_MODE_SEL] != int_mode);
	wire int_clear = int_mode && (rd_done || ara_done || (wr_conf && shift[`TLASA_CONF_SHUTDOWN]));

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			alert <= 1'b0;
			arm_high <= 1'b1;
			fault_cnt <= 3'h0;
		end else if (gc_reset || mode_chg) begin
			alert <= 1'b0;
			arm_high <= 1'b1;
			fault_cnt <= 3'h0;
		end else begin
			if (counting) fault_cnt <= (cond && !qualify) ? fault_cnt + 3'h1 : 3'h0;
			if (qualify) begin
				arm_high <= ~arm_high;
				alert <= int_mode ? 1'b1 : arm_high;
			end else if (int_clear) begin
				alert <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) alert_out <= 1'b1;
		else alert_out <= conf[`TLASA_CONF_POLARITY] ? alert : ~alert;
	end

	sequence s_single_write;
		single_req && !conv_busy && !single_pend;
	endsequence
	sequence s_one_shot_end;
		conv_fin && conf[`TLASA_CONF_SHUTDOWN] && !single_pend && !single_req && !wr_conf
			##1 !wr_conf;
	endsequence

	a_one_shot_start: assert property (@(posedge clock_in) disable iff (rst_in)
		s_single_write |-> ##[1:2] conv_start_out) else $error("one-shot did not start");
	a_one_shot_stop: assert property (@(posedge clock_in) disable iff (rst_in)
		s_one_shot_end |=> !conv_start_out && !conv_busy) else $error("no return to shutdown");
	a_single_reads_zero: assert property (@(posedge clock_in) disable iff (rst_in)
		(ptr == `TLASA_PTR_CONF && !is_ara) |-> !rd_byte[7]) else $error("one-shot bit read one");
	a_upper_alert: assert property (@(posedge clock_in) disable iff (rst_in)
		(counting && arm_high && over && fault_cnt + 3'h1 == fault_need && !mode_chg && !gc_reset)
		|=> alert ##1 (alert_out == conf[`TLASA_CONF_POLARITY])) else $error("upper alert missing");
	a_lower_release: assert property (@(posedge clock_in) disable iff (rst_in)
		(!int_mode && counting && !arm_high && under && fault_cnt + 3'h1 == fault_need
		&& !mode_chg && !gc_reset) |=> !alert && arm_high) else $error("comparator alert not released");
	a_int_read_clear: assert property (@(posedge clock_in) disable iff (rst_in)
		(int_mode && alert && rd_done && !mode_chg) |=> !alert) else $error("read did not clear alert");
	a_int_shutdown_clear: assert property (@(posedge clock_in) disable iff (rst_in)
		(int_mode && !qualify && wr_conf && shift[`TLASA_CONF_SHUTDOWN] && !mode_chg) |=> !alert)
		else $error("shutdown did not clear alert");
	a_int_rearm: assert property (@(posedge clock_in) disable iff (rst_in)
		(int_mode && qualify && !mode_chg && !gc_reset) |=> alert && (arm_high != $past(arm_high)))
		else $error("threshold did not alternate");
	a_gc_reset: assert property (@(posedge clock_in) disable iff (rst_in)
		gc_reset |=> !alert && upper == `TLASA_HIGH_RESET && lower == `TLASA_LOW_RESET)
		else $error("general call reset incomplete");
	a_mode_clear: assert property (@(posedge clock_in) disable iff (rst_in)
		mode_chg |=> !alert && arm_high && fault_cnt == 3'h0) else $error("mode change kept state");
	a_fault_bound: assert property (@(posedge clock_in) disable iff (rst_in)
		fault_cnt < fault_need || $past(wr_conf)) else $error("fault count beyond queue length");
	a_ack_drive: assert property (@(posedge clock_in) disable iff (rst_in)
		(state == tlasa_pkg::ST_ACK_ADDR || state == tlasa_pkg::ST_ACK_WRITE) |-> sda_oe_out)
		else $error("acknowledge not driven low");
	a_host_slot: assert property (@(posedge clock_in) disable iff (rst_in)
		(state == tlasa_pkg::ST_ACK_READ) |-> !sda_oe_out) else $error("SDA driven in host slot");
	a_polarity: assert property (@(posedge clock_in) disable iff (rst_in)
		##1 alert_out == ($past(conf[`TLASA_CONF_POLARITY]) ? $past(alert) : !$past(alert)))
		else $error("alert polarity wrong");
endmodule

// File: dv/tlasa_host.sv
// Purpose: Two-wire bus controller model facing the limit alert block.
// Assumes: sda_wire_in is the resolved, pulled-up data wire.
// Notes: SCL half period is 8 clocks; SCL and SDA stand high between frames.
`timescale 1ns/1ps
module tlasa_host (
	input wire logic clock_in,
	input wire logic sda_wire_in,
	output logic scl_out,
	output logic sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic drive(input logic c, input logic d, input int n);
		scl_out <= c;
		sda_out <= d;
		repeat (n) @(posedge clock_in);
	endtask
	task automatic start();
		drive(1'b1, 1'b1, 8);
		drive(1'b1, 1'b0, 8);
		drive(1'b0, 1'b0, 4);
	endtask
	task automatic stop();
		drive(1'b0, 1'b0, 4);
		drive(1'b1, 1'b0, 8);
		drive(1'b1, 1'b1, 8);
	endtask
	task automatic bit_out(input logic b);
		drive(1'b0, b, 4);
		drive(1'b1, b, 8);
		drive(1'b0, b, 4);
	endtask
	task automatic bit_in(output logic b);
		drive(1'b0, 1'b1, 4);
		drive(1'b1, 1'b1, 4);
		b = sda_wire_in;
		drive(1'b1, 1'b1, 4);
		drive(1'b0, 1'b1, 4);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(ack);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_in(b);
			d[i] = b;
		end
		bit_out(last);
	endtask
endmodule

// File: dv/temp_limit_alert_serial_access_bench.sv
// Purpose: Self-checking bench of the limit alert block.
// Assumes: The bench plays the converter; tlasa_host plays the bus controller.
// Notes: Random limits and temperatures come from a fixed seed.
`timescale 1ns/1ps
module temp_limit_alert_serial_access_bench;
	localparam logic [6:0] DEV = 7'h2A;
	logic clock_in, rst_in, conv_done_in, scl, sda_host, sda_out, sda_oe_out, alert_out;
	logic conv_start_out, ack, polarity;
	logic [11:0] conv_temp_in, up, lo;
	logic [1:0] conv_rate_out;
	logic [15:0] rd;
	int n_fail = 0, tests_run = 0, n_start = 0, n_done = 0;
	wire logic sda_wire = sda_host & ~sda_oe_out;
	tlasa_sensor #(.DEV_ADDR(DEV)) tlasa_sensor_i (.clock_in(clock_in), .rst_in(rst_in),
		.scl_in(scl), .sda_in(sda_wire), .conv_done_in(conv_done_in),
		.conv_temp_in(conv_temp_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.alert_out(alert_out), .conv_start_out(conv_start_out), .conv_rate_out(conv_rate_out));
	tlasa_host tlasa_host_i (.clock_in(clock_in), .sda_wire_in(sda_wire), .scl_out(scl),
		.sda_out(sda_host));
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		if (conv_start_out === 1'b1) n_start <= n_start + 1;
	end
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: level %b, expected %b", $time, got, exp);
		end
	endtask
	function automatic logic pin(input logic act);
		return ~(act ^ polarity);
	endfunction
	function automatic int nfault(input logic [1:0] fq);
		return (fq == 2'h0) ? 1 : (fq == 2'h1) ? 2 : (fq == 2'h2) ? 4 : 6;
	endfunction
	function automatic logic [7:0] cfg(input logic single, input logic [1:0] fq, input logic p,
		input logic mode, input logic shut);
		return {single, fq, fq, p, mode, shut};
	endfunction
	function automatic logic [11:0] hot();
		return up + 12'($urandom % 16);
	endfunction
	function automatic logic [11:0] cold();
		return lo - 12'h001 - 12'($urandom % 16);
	endfunction
	task automatic send(input logic [31:0] w, input int nb, input logic nack0);
		tlasa_host_i.start();
		for (int i = 0; i < nb; i++) begin
			tlasa_host_i.wbyte(w[31 - 8 * i -: 8], ack);
			chk1(ack, (i == 0) ? nack0 : 1'b0);
		end
		tlasa_host_i.stop();
	endtask
	task automatic wcfg(input logic [7:0] c);
		send({DEV, 1'b0, 8'h01, c, 8'h00}, 4, 1'b0);
	endtask
	task automatic rd_bytes(input logic [6:0] a, input int nb);
		logic [7:0] b;
		rd = 16'h0000;
		tlasa_host_i.start();
		tlasa_host_i.wbyte({a, 1'b1}, ack);
		chk1(ack, 1'b0);
		for (int i = 0; i < nb; i++) begin
			tlasa_host_i.rbyte(i == nb - 1, b);
			rd = {rd[7:0], b};
		end
		tlasa_host_i.stop();
	endtask
	task automatic rreg(input logic [1:0] p, input int nb);
		send({DEV, 1'b0, 6'h00, p, 16'h0000}, 2, 1'b0);
		rd_bytes(DEV, nb);
	endtask
	task automatic conv(input logic [11:0] t);
		for (int k = 0; k < 200 && n_start == n_done; k++) @(posedge clock_in);
		if (n_start == n_done) begin
			n_fail++;
			$display("ERROR %0t: no conversion start", $time);
			final_report();
		end
		n_done++;
		conv_temp_in <= t;
		conv_done_in <= 1'b1;
		@(posedge clock_in);
		conv_done_in <= 1'b0;
		repeat (4) @(posedge clock_in);
	endtask
	initial begin
		int n;
		rst_in = 1'b1;
		conv_done_in = 1'b0;
		conv_temp_in = 12'h000;
		polarity = 1'b0;
		void'($urandom(94));
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		rreg(2'h3, 2); chk16(rd, 16'h5000);
		rreg(2'h2, 2); chk16(rd, 16'h4B00);
		rreg(2'h1, 1); chk16(rd, 16'h0028);
		send({7'h55, 1'b0, 24'h000000}, 1, 1'b1);
		up = 12'h200 + 12'($urandom % 256);
		lo = up - 12'h040;
		send({DEV, 1'b0, 8'h03, up, 4'hF}, 4, 1'b0);
		send({DEV, 1'b0, 8'h02, lo, 4'h5}, 4, 1'b0);
		rreg(2'h3, 2); chk16(rd, {up, 4'h0});
		rreg(2'h2, 2); chk16(rd, {lo, 4'h0});
		for (int j = 0; j < 4; j++) begin
			n = nfault(2'(j));
			wcfg(cfg(1'b0, 2'(j), 1'b0, 1'b0, 1'b0));
			chk16(16'(conv_rate_out), 16'(j));
			repeat (n - 1) conv(hot());
			conv(cold());
			repeat (n - 1) conv(hot());
			chk1(alert_out, pin(1'b0));
			conv(hot());
			chk1(alert_out, pin(1'b1));
			repeat (n - 1) conv(cold());
			chk1(alert_out, pin(1'b1));
			conv(cold());
			chk1(alert_out, pin(1'b0));
		end
		wcfg(cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
		conv(hot()); chk1(alert_out, pin(1'b1));
		conv(hot()); chk1(alert_out, pin(1'b1));
		rreg(2'h0, 1); chk1(alert_out, pin(1'b0));
		conv(hot()); chk1(alert_out, pin(1'b0));
		conv(cold()); chk1(alert_out, pin(1'b1));
		rd_bytes(7'h0C, 1); chk16(rd, {8'h00, DEV, 1'b0});
		chk1(alert_out, pin(1'b0));
		conv(hot()); chk1(alert_out, pin(1'b1));
		wcfg(cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0)); chk1(alert_out, pin(1'b0));
		wcfg(cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
		conv(hot()); chk1(alert_out, pin(1'b1));
		wcfg(cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b1)); chk1(alert_out, pin(1'b0));
		conv(hot());
		repeat (60) @(posedge clock_in);
		chk16(16'(n_start - n_done), 16'h0000);
		wcfg(cfg(1'b1, 2'h0, 1'b0, 1'b1, 1'b1));
		conv(hot());
		repeat (60) @(posedge clock_in);
		chk16(16'(n_start - n_done), 16'h0000);
		rreg(2'h1, 1); chk16(rd, {8'h00, cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b1)});
		polarity = 1'b1;
		wcfg(cfg(1'b0, 2'h0, 1'b1, 1'b0, 1'b0)); chk1(alert_out, pin(1'b0));
		conv(hot()); chk1(alert_out, pin(1'b1));
		send({7'h00, 1'b0, 8'h06, 16'h0000}, 2, 1'b0);
		polarity = 1'b0;
		chk1(alert_out, pin(1'b0));
		rreg(2'h3, 2); chk16(rd, 16'h5000);
		final_report();
	end
endmodule
